// >>> src/pmcr_regs.sv
// manufacturer configuration register bank with output-voltage floor
`timescale 1ns/100ps
module pmcr_regs #(
    // fixed identity bytes: arbitrary neutral values
    parameter logic [7:0] MAKER_FIXED_BYTE   = 8'hA5,
    parameter logic [7:0] MODEL_FIXED_BYTE   = 8'hA5,
    parameter logic [3:0] REV_FIXED_NIBBLE   = 4'h3,
    parameter logic [7:0] REV_FIXED_BYTE     = 8'hA5,
    parameter logic [7:0] DATE_FIXED_BYTE    = 8'hA5,
    // stored copies at power-up: arbitrary neutral values
    parameter logic [7:0] MAKER_NVM_BYTE     = 8'h5A,
    parameter logic [7:0] MODEL_NVM_BYTE     = 8'h5A,
    parameter logic [3:0] REV_NVM_NIBBLE     = 4'hC,
    parameter logic [7:0] DATE_NVM_BYTE      = 8'h5A
) (
    input  wire logic        core_clk_i,
    input  wire logic        resetn_i,
    input  wire logic [7:0]  cmd_code_i,
    input  wire logic        cmd_wr_i,
    input  wire logic [15:0] cmd_wr_data_i,
    output logic      [15:0] rd_data_o,
    output logic             rd_hit_o,
    input  wire logic        vout_cmd_valid_i,
    input  wire logic [7:0]  vout_cmd_vid_i,
    output logic      [7:0]  vout_target_vid_o,
    output logic             vout_clamped_o,
    output logic             output_enable_o,
    input  wire logic        clear_faults_i,
    output logic             status_other_o,
    output logic             status_vout_o,
    output logic             vout_min_warn_o,
    output logic             pmbus_alert_o,
    input  wire logic [15:0] meas_vout_i,
    input  wire logic [3:0]  overcurrent_strap_pin_i,
    output logic      [3:0]  valley_limit_code_o,
    output logic      [6:0]  valley_limit_amps_o,
    output logic      [2:0]  pin_avg_code_o,
    output logic      [1:0]  iv_avg_code_o,
    output logic      [17:0] pin_avg_us_o,
    output logic      [11:0] iv_avg_us_o
);

    logic        rst_n;
    logic [3:0]  strap_code;

    // helpers

    // amperes for a valley limit code: base plus code times step
    function automatic logic [6:0] valley_amps(input logic [3:0] code);
        logic [6:0] prod;
        prod = 7'(code) * pmcr_pkg::VALLEY_STEP_A;
        return pmcr_pkg::VALLEY_BASE_A + prod;
    endfunction

    // does a command code address the given register
    function automatic logic is_cmd(input logic [7:0] code, input logic [7:0] reg_code);
        return code == reg_code;
    endfunction

    // reset and pin synchronisers

    pmcr_rst_sync u_rst_sync (
        .core_clk_i (core_clk_i),
        .resetn_i   (resetn_i),
        .rst_n_o    (rst_n)
    );

    // strap pin is static in use but still crosses from outside
    pmcr_pin_sync #(
        .WIDTH (4),
        .RST   (pmcr_pkg::VALLEY_NVM_RST)
    ) u_strap_sync (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n),
        .pin_i      (overcurrent_strap_pin_i),
        .value_o    (strap_code)
    );

    // writable register fields

    logic [7:0] maker_code_writable_byte_q, maker_code_writable_byte_d;
    logic [7:0] model_writable_byte_q,      model_writable_byte_d;
    logic [3:0] revision_writable_nibble_q, revision_writable_nibble_d;
    logic [7:0] date_writable_byte_q,       date_writable_byte_d;
    logic [7:0] vout_floor_q,               vout_floor_d;
    logic [3:0] valley_limit_code_q,        valley_limit_code_d;
    logic       valley_written_q,           valley_written_d;
    logic [2:0] pin_avg_q,                  pin_avg_d;
    logic [1:0] iv_avg_q,                   iv_avg_d;

    // only writable slices are taken, fixed and reserved bits are dropped
    always_comb begin
        maker_code_writable_byte_d = maker_code_writable_byte_q;
        model_writable_byte_d      = model_writable_byte_q;
        revision_writable_nibble_d = revision_writable_nibble_q;
        date_writable_byte_d       = date_writable_byte_q;
        vout_floor_d               = vout_floor_q;
        valley_limit_code_d        = valley_limit_code_q;
        valley_written_d           = valley_written_q;
        pin_avg_d                  = pin_avg_q;
        iv_avg_d                   = iv_avg_q;
        if (cmd_wr_i) begin
            if (is_cmd(cmd_code_i, pmcr_pkg::CMD_MAKER_ID)) begin
                maker_code_writable_byte_d = cmd_wr_data_i[pmcr_pkg::BYTE_HI_LSB +: 8];
            end
            if (is_cmd(cmd_code_i, pmcr_pkg::CMD_MODEL_ID)) begin
                model_writable_byte_d = cmd_wr_data_i[pmcr_pkg::BYTE_HI_LSB +: 8];
            end
            if (is_cmd(cmd_code_i, pmcr_pkg::CMD_REVISION_ID)) begin
                revision_writable_nibble_d = cmd_wr_data_i[pmcr_pkg::REV_NIB_LSB +: 4];
            end
            if (is_cmd(cmd_code_i, pmcr_pkg::CMD_BUILD_DATE)) begin
                date_writable_byte_d = cmd_wr_data_i[pmcr_pkg::BYTE_HI_LSB +: 8];
            end
            if (is_cmd(cmd_code_i, pmcr_pkg::CMD_VOUT_FLOOR)) begin
                vout_floor_d = cmd_wr_data_i[7:0];
            end
            if (is_cmd(cmd_code_i, pmcr_pkg::CMD_VALLEY_LIMIT)) begin
                valley_limit_code_d = cmd_wr_data_i[3:0];
                valley_written_d    = 1'b1;
            end
            if (is_cmd(cmd_code_i, pmcr_pkg::CMD_TELEM_AVG)) begin
                pin_avg_d = cmd_wr_data_i[pmcr_pkg::PIN_AVG_LSB +: 3];
                iv_avg_d  = cmd_wr_data_i[pmcr_pkg::IV_AVG_LSB +: 2];
            end
        end
    end

    // stored copies load at power-up; there is no separate recall path
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            maker_code_writable_byte_q <= MAKER_NVM_BYTE;
            model_writable_byte_q      <= MODEL_NVM_BYTE;
            revision_writable_nibble_q <= REV_NVM_NIBBLE;
            date_writable_byte_q       <= DATE_NVM_BYTE;
            vout_floor_q               <= pmcr_pkg::VOUT_FLOOR_RST;
            valley_limit_code_q        <= pmcr_pkg::VALLEY_NVM_RST;
            valley_written_q           <= 1'b1;
            pin_avg_q                  <= pmcr_pkg::PIN_AVG_RST;
            iv_avg_q                   <= pmcr_pkg::IV_AVG_RST;
        end else begin
            maker_code_writable_byte_q <= maker_code_writable_byte_d;
            model_writable_byte_q      <= model_writable_byte_d;
            revision_writable_nibble_q <= revision_writable_nibble_d;
            date_writable_byte_q       <= date_writable_byte_d;
            vout_floor_q               <= vout_floor_d;
            valley_limit_code_q        <= valley_limit_code_d;
            valley_written_q           <= valley_written_d;
            pin_avg_q                  <= pin_avg_d;
            iv_avg_q                   <= iv_avg_d;
        end
    end

    // voltage floor clamp and warning flags

    logic [7:0] vout_target_q, vout_target_d;
    logic       clamped_q,     clamped_d;
    logic       other_q,       other_d;
    logic       vout_bit_q,    vout_bit_d;
    logic       min_warn_q,    min_warn_d;
    logic       below_floor;

    assign below_floor = vout_cmd_valid_i && (vout_cmd_vid_i < vout_floor_q);

    // a new event in the clearing cycle wins, so none is lost
    always_comb begin
        vout_target_d = vout_target_q;
        clamped_d     = 1'b0;
        other_d       = clear_faults_i ? 1'b0 : other_q;
        vout_bit_d    = clear_faults_i ? 1'b0 : vout_bit_q;
        min_warn_d    = clear_faults_i ? 1'b0 : min_warn_q;
        if (vout_cmd_valid_i) begin
            vout_target_d = below_floor ? vout_floor_q : vout_cmd_vid_i;
        end
        if (below_floor) begin
            clamped_d  = 1'b1;
            other_d    = 1'b1;
            vout_bit_d = 1'b1;
            min_warn_d = 1'b1;
        end
    end

    // target, clamp pulse and sticky flags, all clear under reset
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            vout_target_q <= 8'h00;
            clamped_q     <= 1'b0;
            other_q       <= 1'b0;
            vout_bit_q    <= 1'b0;
            min_warn_q    <= 1'b0;
        end else begin
            vout_target_q <= vout_target_d;
            clamped_q     <= clamped_d;
            other_q       <= other_d;
            vout_bit_q    <= vout_bit_d;
            min_warn_q    <= min_warn_d;
        end
    end

    assign vout_target_vid_o = vout_target_q;
    assign vout_clamped_o    = clamped_q;
    assign status_other_o    = other_q;
    assign status_vout_o     = vout_bit_q;
    assign vout_min_warn_o   = min_warn_q;
    assign pmbus_alert_o     = min_warn_q;
    // a floor hit never disables the rail
    assign output_enable_o   = rst_n;

    // readback and effective settings

    logic [15:0] voltage_readback_mantissa_q, voltage_readback_mantissa_d;
    logic [15:0] rd_data_q,                   rd_data_d;
    logic        rd_hit_q,                    rd_hit_d;
    logic [3:0]  eff_code;
    logic [7:0]  telem_avg_word;

    // register value always wins; valley_written_q is set at reset, so the strap is never chosen
    assign eff_code       = valley_written_q ? valley_limit_code_q : strap_code;
    // reserved bits 7, 3 and 2 are tied low
    assign telem_avg_word = {1'b0, pin_avg_q, 2'b00, iv_avg_q};

    // measured voltage sampled each cycle, host cannot write it
    always_comb begin
        voltage_readback_mantissa_d = meas_vout_i;
        rd_hit_d  = 1'b1;
        case (cmd_code_i)
            pmcr_pkg::CMD_MAKER_ID: begin
                rd_data_d = {maker_code_writable_byte_q, MAKER_FIXED_BYTE};
            end
            pmcr_pkg::CMD_MODEL_ID: begin
                rd_data_d = {model_writable_byte_q, MODEL_FIXED_BYTE};
            end
            pmcr_pkg::CMD_REVISION_ID: begin
                rd_data_d = {REV_FIXED_NIBBLE, revision_writable_nibble_q,
                             REV_FIXED_BYTE};
            end
            pmcr_pkg::CMD_BUILD_DATE: begin
                rd_data_d = {date_writable_byte_q, DATE_FIXED_BYTE};
            end
            pmcr_pkg::CMD_VOUT_FLOOR: begin
                rd_data_d = {8'h00, vout_floor_q};
            end
            pmcr_pkg::CMD_VALLEY_LIMIT: begin
                rd_data_d = {12'h000, valley_limit_code_q};
            end
            pmcr_pkg::CMD_TELEM_AVG: begin
                rd_data_d = {8'h00, telem_avg_word};
            end
            pmcr_pkg::CMD_VOUT_LINEAR: begin
                rd_data_d = voltage_readback_mantissa_q;
            end
            default: begin
                rd_data_d = 16'h0000;
                rd_hit_d  = 1'b0;
            end
        endcase
    end

    // read word registered so the host sees a settled value
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            voltage_readback_mantissa_q <= 16'h0000;
            rd_data_q                   <= 16'h0000;
            rd_hit_q                    <= 1'b0;
        end else begin
            voltage_readback_mantissa_q <= voltage_readback_mantissa_d;
            rd_data_q                   <= rd_data_d;
            rd_hit_q                    <= rd_hit_d;
        end
    end

    assign rd_data_o           = rd_data_q;
    assign rd_hit_o            = rd_hit_q;
    assign valley_limit_code_o = eff_code;
    assign valley_limit_amps_o = valley_amps(eff_code);
    assign pin_avg_code_o      = pin_avg_q;
    assign iv_avg_code_o       = iv_avg_q;
    assign pin_avg_us_o        = pmcr_pkg::PIN_AVG_US[pin_avg_q];
    assign iv_avg_us_o         = pmcr_pkg::IV_AVG_US[iv_avg_q];

endmodule

// >>> src/pmcr_pkg.sv
// constants for the manufacturer configuration register bank
package pmcr_pkg;

    // command codes, one per register
    localparam logic [7:0]  CMD_MAKER_ID      = 8'h99;
    localparam logic [7:0]  CMD_MODEL_ID      = 8'h9A;
    localparam logic [7:0]  CMD_REVISION_ID   = 8'h9B;
    localparam logic [7:0]  CMD_BUILD_DATE    = 8'h9D;
    localparam logic [7:0]  CMD_VOUT_FLOOR    = 8'hA4;
    localparam logic [7:0]  CMD_VALLEY_LIMIT  = 8'hD0;
    localparam logic [7:0]  CMD_TELEM_AVG     = 8'hD1;
    localparam logic [7:0]  CMD_VOUT_LINEAR   = 8'hD4;

    // field positions
    localparam int          BYTE_HI_LSB       = 8;
    localparam int          REV_NIB_LSB       = 8;
    localparam int          REV_TOP_LSB       = 12;
    localparam int          PIN_AVG_LSB       = 4;
    localparam int          IV_AVG_LSB        = 0;

    // reset values
    localparam logic [7:0]  VOUT_FLOOR_RST    = 8'h00;
    localparam logic [3:0]  VALLEY_NVM_RST    = 4'h8;
    localparam logic [2:0]  PIN_AVG_RST       = 3'h5;
    localparam logic [1:0]  IV_AVG_RST        = 2'h0;
    localparam logic [7:0]  TELEM_AVG_RST     = 8'h50;

    // valley current limit scale in amperes
    localparam logic [6:0]  VALLEY_BASE_A     = 7'h18;
    localparam logic [6:0]  VALLEY_STEP_A     = 7'h03;

    // linear readback exponent, two's complement -9
    localparam logic [4:0]  VOUT_LIN_EXP      = 5'h17;

    // averaging times in microseconds, per code
    localparam logic [17:0] PIN_AVG_US [8]    = '{18'h00000, 18'h007D0, 18'h0157C, 18'h02CEC,
                                                  18'h04A38, 18'h0C350, 18'h186A0, 18'h36EE8};
    localparam logic [11:0] IV_AVG_US  [4]    = '{12'h000, 12'h1F4, 12'h3E8, 12'h9C4};

endpackage

// >>> src/pmcr_rst_sync.sv
// reset release synchroniser, two flip-flops
`timescale 1ns/100ps
module pmcr_rst_sync (
    input  wire logic core_clk_i,
    input  wire logic resetn_i,
    output logic      rst_n_o
);
    logic [1:0] sync_q;
    logic [1:0] sync_d;

    // shift a one in after release, assert at once
    always_comb begin
        sync_d = {sync_q[0], 1'b1};
    end

    // clears at once, releases only on the clock
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sync_q <= 2'b00;
        end else begin
            sync_q <= sync_d;
        end
    end

    assign rst_n_o = sync_q[1];
endmodule

// >>> src/pmcr_pin_sync.sv
// three-stage pin synchroniser, change accepted when last two stages agree
`timescale 1ns/100ps
module pmcr_pin_sync #(
    parameter int              WIDTH = 4,
    parameter logic [WIDTH-1:0] RST  = '0
) (
    input  wire logic             core_clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] pin_i,
    output logic      [WIDTH-1:0] value_o
);
    logic [WIDTH-1:0] s1_q, s2_q, s3_q, val_q;
    logic [WIDTH-1:0] s1_d, s2_d, s3_d, val_d;

    // stage one is only seen by stage two
    always_comb begin
        s1_d  = pin_i;
        s2_d  = s1_q;
        s3_d  = s2_q;
        val_d = (s2_q == s3_q) ? s3_q : val_q;
    end

    // pin stages and accepted value share one reset
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_q  <= RST;
            s2_q  <= RST;
            s3_q  <= RST;
            val_q <= RST;
        end else begin
            s1_q  <= s1_d;
            s2_q  <= s2_d;
            s3_q  <= s3_d;
            val_q <= val_d;
        end
    end

    assign value_o = val_q;
endmodule

// >>> verification/pmcr_regs_sva.sv
// assertion checker for the configuration register bank
`timescale 1ns/100ps
module pmcr_regs_sva (
    input wire logic        core_clk_i,
    input wire logic        resetn_i,
    input wire logic [7:0]  cmd_code_i,
    input wire logic        cmd_wr_i,
    input wire logic [15:0] cmd_wr_data_i,
    input wire logic [15:0] rd_data_o,
    input wire logic        vout_cmd_valid_i,
    input wire logic [7:0]  vout_cmd_vid_i,
    input wire logic [7:0]  vout_target_vid_o,
    input wire logic        vout_clamped_o,
    input wire logic        output_enable_o,
    input wire logic        clear_faults_i,
    input wire logic        status_other_o,
    input wire logic        status_vout_o,
    input wire logic        vout_min_warn_o,
    input wire logic        pmbus_alert_o,
    input wire logic [3:0]  valley_limit_code_o,
    input wire logic [6:0]  valley_limit_amps_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    logic [7:0] floor_q;
    logic       below;
    // shadow of the floor so commands can be judged from the ports alone
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) floor_q <= 8'h00;
        else if (cmd_wr_i && cmd_code_i == pmcr_pkg::CMD_VOUT_FLOOR) floor_q <= cmd_wr_data_i[7:0];
    end
    assign below = vout_cmd_valid_i && (vout_cmd_vid_i < floor_q);
    // floor write followed by a read of the same code
    sequence s_floor_wr;
        cmd_wr_i && cmd_code_i == pmcr_pkg::CMD_VOUT_FLOOR ##1
            !cmd_wr_i && cmd_code_i == pmcr_pkg::CMD_VOUT_FLOOR;
    endsequence
    a_floor_read_back: assert property (
        s_floor_wr |=> rd_data_o == {8'h00, $past(cmd_wr_data_i[7:0], 2)})
        else $error("floor read back wrong");
    a_target_floor: assert property (
        vout_cmd_valid_i |=> vout_target_vid_o ==
            ($past(below) ? $past(floor_q) : $past(vout_cmd_vid_i)))
        else $error("target not clamped to floor");
    a_clamp_pulse: assert property (1 |=> vout_clamped_o == $past(below))
        else $error("clamp pulse wrong");
    a_warn_set: assert property (
        below |=> status_other_o && status_vout_o && vout_min_warn_o)
        else $error("status flags not set");
    a_alert_tracks: assert property (pmbus_alert_o == vout_min_warn_o)
        else $error("alert differs from warning");
    a_enable_held: assert property (output_enable_o |=> output_enable_o)
        else $error("output dropped");
    a_flags_clear: assert property (
        clear_faults_i && !below |=> !(status_other_o || status_vout_o || vout_min_warn_o))
        else $error("flags not cleared");
    a_warn_sticky: assert property ($fell(vout_min_warn_o) |-> $past(clear_faults_i))
        else $error("warning fell without clear");
    a_valley_scale: assert property (
        valley_limit_amps_o == 7'h18 + 7'h03 * {3'h0, valley_limit_code_o})
        else $error("valley amps wrong");
endmodule
bind pmcr_regs pmcr_regs_sva chk_u (.core_clk_i, .resetn_i, .cmd_code_i, .cmd_wr_i,
    .cmd_wr_data_i, .rd_data_o, .vout_cmd_valid_i, .vout_cmd_vid_i, .vout_target_vid_o,
    .vout_clamped_o, .output_enable_o, .clear_faults_i, .status_other_o, .status_vout_o,
    .vout_min_warn_o, .pmbus_alert_o, .valley_limit_code_o, .valley_limit_amps_o);

// >>> verification/pmcr_host_model.sv
// host-side model driving register and voltage requests
`timescale 1ns/100ps
module pmcr_host_model (
    input  wire logic        core_clk_i,
    input  wire logic [15:0] rd_data_i,
    input  wire logic        rd_hit_i,
    output logic      [7:0]  cmd_code_o,
    output logic             cmd_wr_o,
    output logic      [15:0] cmd_wr_data_o,
    output logic             vout_cmd_valid_o,
    output logic      [7:0]  vout_cmd_vid_o,
    output logic             clear_faults_o
);
    // idle at time zero
    initial begin
        cmd_code_o = 8'h00;
        cmd_wr_o = 1'b0;
        cmd_wr_data_o = 16'h0000;
        vout_cmd_valid_o = 1'b0;
        vout_cmd_vid_o = 8'h00;
        clear_faults_o = 1'b0;
    end
    // one-cycle write; data inverted after so stale values never look valid
    task automatic write_reg(input logic [7:0] code, input logic [15:0] data);
        @(posedge core_clk_i);
        cmd_code_o <= code;
        cmd_wr_o <= 1'b1;
        cmd_wr_data_o <= data;
        @(posedge core_clk_i);
        cmd_wr_o <= 1'b0;
        cmd_wr_data_o <= ~data;
    endtask
    // code held two edges so any earlier write has landed
    task automatic read_reg(input logic [7:0] code, output logic [15:0] data, output logic hit);
        @(posedge core_clk_i);
        cmd_code_o <= code;
        @(posedge core_clk_i);
        @(posedge core_clk_i);
        #1;
        data = rd_data_i;
        hit = rd_hit_i;
    endtask
    // voltage command and/or clear, returns just after the answer edge
    task automatic drive(input logic go, input logic [7:0] vid, input logic clr);
        @(posedge core_clk_i);
        vout_cmd_valid_o <= go;
        vout_cmd_vid_o <= vid;
        clear_faults_o <= clr;
        @(posedge core_clk_i);
        vout_cmd_valid_o <= 1'b0;
        vout_cmd_vid_o <= ~vid;
        clear_faults_o <= 1'b0;
        #1;
    endtask
endmodule

// >>> verification/pmbus_mfr_config_registers_bench.sv
// self-checking bench for the configuration register bank
`timescale 1ns/100ps
module pmbus_mfr_config_registers_bench;
    localparam logic [7:0]  FIX_B = 8'h3C; // arbitrary fixed identity byte
    localparam logic [3:0]  FIX_N = 4'h6;  // arbitrary fixed identity nibble
    localparam logic [7:0]  IDS [4] = '{8'h99, 8'h9A, 8'h9B, 8'h9D};
    localparam logic [17:0] PIN_US [8] = '{18'h00000, 18'h007D0, 18'h0157C, 18'h02CEC,
                                           18'h04A38, 18'h0C350, 18'h186A0, 18'h36EE8};
    localparam logic [17:0] IV_US [4] = '{18'h00000, 18'h001F4, 18'h003E8, 18'h009C4};
    logic        core_clk_i, resetn_i, cmd_wr_i, rd_hit_o, vout_cmd_valid_i;
    logic        vout_clamped_o, output_enable_o, clear_faults_i, status_other_o;
    logic        status_vout_o, vout_min_warn_o, pmbus_alert_o;
    logic [7:0]  cmd_code_i, vout_cmd_vid_i, vout_target_vid_o;
    logic [15:0] cmd_wr_data_i, rd_data_o, meas_vout_i;
    logic [3:0]  overcurrent_strap_pin_i, valley_limit_code_o;
    logic [6:0]  valley_limit_amps_o;
    logic [2:0]  pin_avg_code_o;
    logic [1:0]  iv_avg_code_o;
    logic [17:0] pin_avg_us_o;
    logic [11:0] iv_avg_us_o;
    int          err_count, checks_done, cycles;

    pmcr_regs #(.MAKER_FIXED_BYTE(FIX_B), .MODEL_FIXED_BYTE(FIX_B), .REV_FIXED_NIBBLE(FIX_N),
        .REV_FIXED_BYTE(FIX_B), .DATE_FIXED_BYTE(FIX_B)) dut_u (.core_clk_i, .resetn_i,
        .cmd_code_i, .cmd_wr_i, .cmd_wr_data_i, .rd_data_o, .rd_hit_o, .vout_cmd_valid_i,
        .vout_cmd_vid_i, .vout_target_vid_o, .vout_clamped_o, .output_enable_o,
        .clear_faults_i, .status_other_o, .status_vout_o, .vout_min_warn_o, .pmbus_alert_o,
        .meas_vout_i, .overcurrent_strap_pin_i, .valley_limit_code_o, .valley_limit_amps_o,
        .pin_avg_code_o, .iv_avg_code_o, .pin_avg_us_o, .iv_avg_us_o);
    pmcr_host_model host_u (.core_clk_i, .rd_data_i(rd_data_o), .rd_hit_i(rd_hit_o),
        .cmd_code_o(cmd_code_i), .cmd_wr_o(cmd_wr_i), .cmd_wr_data_o(cmd_wr_data_i),
        .vout_cmd_valid_o(vout_cmd_valid_i), .vout_cmd_vid_o(vout_cmd_vid_i),
        .clear_faults_o(clear_faults_i));

    // 100 MHz clock
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end
    task automatic chk_word(input logic [17:0] got, input logic [17:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    // status vector {clamped, other, vout, warn, alert}
    task automatic chk_stat(input logic [4:0] exp);
        chk_word({13'h0000, vout_clamped_o, status_other_o, status_vout_o, vout_min_warn_o,
                  pmbus_alert_o}, {13'h0000, exp});
    endtask
    task automatic rd_expect(input logic [7:0] code, input logic [15:0] exp, input logic hit);
        logic [15:0] d;
        logic        h;
        host_u.read_reg(code, d, h);
        chk_word({2'h0, d}, {2'h0, exp});
        chk_word({17'h00000, h}, {17'h00000, hit});
    endtask
    task automatic t_reset();
        rd_expect(pmcr_pkg::CMD_TELEM_AVG, 16'h0050, 1'b1);
        rd_expect(pmcr_pkg::CMD_VOUT_FLOOR, 16'h0000, 1'b1);
        rd_expect(pmcr_pkg::CMD_VALLEY_LIMIT, 16'h0008, 1'b1);
        chk_word({13'h0000, pin_avg_code_o, iv_avg_code_o}, 18'h00014);
        chk_word({11'h000, valley_limit_amps_o}, 18'h00030);
        @(posedge core_clk_i);
        meas_vout_i <= 16'hBEEF;
        rd_expect(pmcr_pkg::CMD_VOUT_LINEAR, 16'hBEEF, 1'b1);
        $display("reset values test done");
    endtask
    // fixed bytes must survive both all-ones and all-zeros writes
    task automatic t_ident();
        logic [15:0] d;
        for (int k = 0; k < 2; k++) begin
            d = (k == 0) ? 16'hFFFF : 16'h0000;
            for (int i = 0; i < 4; i++) begin
                host_u.write_reg(IDS[i], d);
                rd_expect(IDS[i], (i == 2) ? {FIX_N, d[11:8], FIX_B} : {d[15:8], FIX_B},
                          1'b1);
            end
        end
        host_u.write_reg(pmcr_pkg::CMD_VOUT_LINEAR, 16'h0000);
        rd_expect(pmcr_pkg::CMD_VOUT_LINEAR, 16'hBEEF, 1'b1);
        host_u.write_reg(8'hEE, 16'hFFFF);
        rd_expect(8'hEE, 16'h0000, 1'b0);
        $display("identity words test done");
    endtask
    task automatic t_limits();
        // strap moved away so only the register can explain the code
        @(posedge core_clk_i);
        overcurrent_strap_pin_i <= 4'hF;
        for (int c = 0; c < 16; c++) begin
            host_u.write_reg(pmcr_pkg::CMD_VALLEY_LIMIT, {12'hFFF, 4'(c)});
            rd_expect(pmcr_pkg::CMD_VALLEY_LIMIT, {12'h000, 4'(c)}, 1'b1);
            chk_word({14'h0000, valley_limit_code_o}, 18'(c));
            chk_word({11'h000, valley_limit_amps_o}, 18'h18 + 18'h03 * 18'(c));
        end
        for (int i = 0; i < 8; i++) begin
            host_u.write_reg(pmcr_pkg::CMD_TELEM_AVG, {9'h1FF, 3'(i), 2'h3, 2'(i)});
            rd_expect(pmcr_pkg::CMD_TELEM_AVG, {9'h000, 3'(i), 2'h0, 2'(i)}, 1'b1);
            chk_word(pin_avg_us_o, PIN_US[i]);
            chk_word({6'h00, iv_avg_us_o}, IV_US[i % 4]);
        end
        $display("limit and averaging test done");
    endtask
    task automatic t_floor();
        host_u.write_reg(pmcr_pkg::CMD_VOUT_FLOOR, 16'hFF40);
        rd_expect(pmcr_pkg::CMD_VOUT_FLOOR, 16'h0040, 1'b1);
        host_u.drive(1'b1, 8'h50, 1'b0);
        chk_word({10'h000, vout_target_vid_o}, 18'h00050);
        chk_stat(5'h00);
        host_u.drive(1'b1, 8'h30, 1'b0);
        chk_word({10'h000, vout_target_vid_o}, 18'h00040);
        chk_stat(5'h1F);
        chk_word({17'h00000, output_enable_o}, 18'h00001);
        host_u.drive(1'b1, 8'h40, 1'b0);
        chk_word({10'h000, vout_target_vid_o}, 18'h00040);
        chk_stat(5'h0F);
        host_u.drive(1'b0, 8'h00, 1'b1);
        chk_stat(5'h00);
        host_u.drive(1'b1, 8'h3F, 1'b1);
        chk_stat(5'h1F);
        $display("voltage floor test done");
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // hang guard, far above the few hundred cycles the tests need
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            $display("Error at %0t: timeout after %0h cycles", $time, cycles);
            complete_run();
        end
    end
    initial begin
        err_count = 0;
        checks_done = 0;
        cycles = 0;
        resetn_i = 1'b0;
        meas_vout_i = 16'h0000;
        overcurrent_strap_pin_i = 4'h2;
        repeat (20) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        t_reset();
        t_ident();
        t_limits();
        t_floor();
        complete_run();
    end
endmodule
